// file: logic/uart_pkg.sv
// Constants and types for the serial port with baud timer
package uart_pkg;
   // Register byte offsets
   localparam logic [4:0] CTRL_OFS = 5'h00;
   localparam logic [4:0] DATA_OFS = 5'h04;
   localparam logic [4:0] TCFG_OFS = 5'h08;
   localparam logic [4:0] RELOAD_OFS = 5'h0C;
   localparam logic [4:0] TLOW_OFS = 5'h10;
   // Control register field positions
   localparam int MODE_BIT = 7;
   localparam int ONE_BIT = 6;
   localparam int MCE_BIT = 5;
   localparam int REN_BIT = 4;
   localparam int TB8_BIT = 3;
   localparam int RB8_BIT = 2;
   localparam int TI_BIT = 1;
   localparam int RI_BIT = 0;
   // Timer config field positions
   localparam int RUN_BIT = 3;
   localparam int IEN_BIT = 4;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h40;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // Timer clock source codes
   localparam logic [2:0] SRC_SYS = 3'h0;
   localparam logic [2:0] SRC_DIV4 = 3'h1;
   localparam logic [2:0] SRC_DIV12 = 3'h2;
   localparam logic [2:0] SRC_DIV48 = 3'h3;
   localparam logic [2:0] SRC_OSC8 = 3'h4;
   localparam logic [2:0] SRC_PIN = 3'h5;
   // Prescaler counts
   localparam logic [5:0] PRE_LAST = 6'h2F;
   localparam logic [5:0] PRE_12A = 6'h0B;
   localparam logic [5:0] PRE_12B = 6'h17;
   localparam logic [5:0] PRE_12C = 6'h23;
   localparam logic [2:0] OSC_LAST = 3'h7;
   localparam logic [7:0] TIMER_TOP = 8'hFF;
   // Frame lengths: last data index and last tx bit index
   localparam logic [3:0] LAST8_DATA = 4'h7;
   localparam logic [3:0] LAST9_DATA = 4'h8;
   localparam logic [3:0] STOP8_IDX = 4'h9;
   localparam logic [3:0] STOP9_IDX = 4'hA;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } tx_state_t;
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_BITS = 4'b0100,
      RX_STOP = 4'b1000
   } rx_state_t;
endpackage : uart_pkg

// file: logic/uart_buffer_and_baud_generator.sv
// Serial port with separate transmit and receive data registers at one address and auto-reload baud timer
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module uart_buffer_and_baud_generator
   import uart_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rx_line,
   output logic tx_line,
   input wire logic ext_osc_clk,
   input wire logic baud_timer_ext_input,
   output logic irq
);
   typedef struct packed {
      logic waitr;
      logic [7:0] rdata;
      logic frame_mode_select;
      logic multiproc_check_enable;
      logic receive_enable_bit;
      logic ninth_tx_bit;
      logic ninth_rx_bit;
      logic tx_done_flag;
      logic rx_done_flag;
      logic [2:0] clk_src;
      logic run;
      logic ien;
      logic irq;
      logic [7:0] baud_timer_reload_byte;
      logic [7:0] baud_timer_low_byte;
      logic [7:0] rx_timer;
      logic tx_half;
      logic rx_half;
      logic [5:0] pre;
      logic [2:0] osc_div;
      logic osc_prev;
      logic pin_prev;
      logic rx_prev;
      logic [7:0] tx_hold;
      logic tx_pend;
      tx_state_t tx_st;
      logic [10:0] tx_shift;
      logic [3:0] tx_cnt;
      logic txd;
      rx_state_t rx_st;
      logic [8:0] rx_shift;
      logic [3:0] rx_cnt;
      logic [7:0] rx_buf;
   } state_t;

   state_t s_reg;
   state_t s_next;
   logic take;
   logic acc;
   logic wr_ctrl;
   logic tick;
   logic osc_rise;
   logic tx_ovf;
   logic rx_ovf;
   logic tx_bit;
   logic rx_smp;
   logic start_det;
   logic chk;
   logic ld;
   logic ti_set;
   logic [3:0] stop_idx;
   logic [3:0] last_data;

   // All next-state logic
   always_comb begin
      s_next = s_reg;
      take = (avs_read | avs_write) & s_reg.waitr;
      acc = (avs_read | avs_write) & ~s_reg.waitr;
      wr_ctrl = acc & avs_write & avs_byteenable[0]
         & (avs_address == CTRL_OFS);
      stop_idx = s_reg.frame_mode_select ? STOP9_IDX : STOP8_IDX;
      last_data = s_reg.frame_mode_select ? LAST9_DATA : LAST8_DATA;
      ti_set = 1'b0;
      ld = 1'b0;
      chk = 1'b0;
      // Bus handshake: one wait cycle, answer on the next
      s_next.waitr = ~take;
      if (take) begin
         case (avs_address)
            CTRL_OFS: s_next.rdata = {s_reg.frame_mode_select, 1'b1,
               s_reg.multiproc_check_enable, s_reg.receive_enable_bit,
               s_reg.ninth_tx_bit, s_reg.ninth_rx_bit,
               s_reg.tx_done_flag, s_reg.rx_done_flag};
            DATA_OFS: s_next.rdata = s_reg.rx_buf;
            TCFG_OFS: s_next.rdata = {3'h0, s_reg.ien, s_reg.run,
               s_reg.clk_src};
            RELOAD_OFS: s_next.rdata = s_reg.baud_timer_reload_byte;
            TLOW_OFS: s_next.rdata = s_reg.baud_timer_low_byte;
            default: s_next.rdata = BYTE_RST;
         endcase
      end
      // Timer clock source selection
      osc_rise = ext_osc_clk & ~s_reg.osc_prev;
      s_next.osc_prev = ext_osc_clk;
      s_next.pin_prev = baud_timer_ext_input;
      s_next.pre = (s_reg.pre == PRE_LAST) ? 6'h00 : s_reg.pre + 6'h01;
      if (osc_rise) begin
         s_next.osc_div = s_reg.osc_div + 3'h1;
      end
      case (s_reg.clk_src)
         SRC_SYS: tick = 1'b1;
         SRC_DIV4: tick = (s_reg.pre[1:0] == 2'b11);
         SRC_DIV12: tick = (s_reg.pre == PRE_12A) | (s_reg.pre == PRE_12B)
            | (s_reg.pre == PRE_12C) | (s_reg.pre == PRE_LAST);
         SRC_DIV48: tick = (s_reg.pre == PRE_LAST);
         SRC_OSC8: tick = osc_rise & (s_reg.osc_div == OSC_LAST);
         SRC_PIN: tick = s_reg.pin_prev & ~baud_timer_ext_input;
         default: tick = 1'b0;
      endcase
      // Transmit counter and its hidden receive copy
      tx_ovf = s_reg.run & tick & (s_reg.baud_timer_low_byte == TIMER_TOP);
      rx_ovf = s_reg.run & tick & (s_reg.rx_timer == TIMER_TOP);
      tx_bit = tx_ovf & s_reg.tx_half;
      rx_smp = rx_ovf & ~s_reg.rx_half;
      start_det = s_reg.rx_prev & ~rx_line & s_reg.receive_enable_bit
         & (s_reg.rx_st == RX_IDLE);
      s_next.rx_prev = rx_line;
      if (s_reg.run & tick) begin
         s_next.baud_timer_low_byte = tx_ovf ? s_reg.baud_timer_reload_byte
            : s_reg.baud_timer_low_byte + 8'h01;
         s_next.rx_timer = rx_ovf ? s_reg.baud_timer_reload_byte
            : s_reg.rx_timer + 8'h01;
      end
      if (tx_ovf) begin
         s_next.tx_half = ~s_reg.tx_half;
      end
      if (rx_ovf) begin
         s_next.rx_half = ~s_reg.rx_half;
      end
      if (start_det) begin
         s_next.rx_timer = s_reg.baud_timer_reload_byte;
         s_next.rx_half = 1'b0;
      end
      // Transmitter
      case (s_reg.tx_st)
         TX_IDLE: begin
            if (s_reg.tx_pend & tx_bit) begin
               s_next.tx_pend = 1'b0;
               s_next.tx_st = TX_SEND;
               s_next.txd = 1'b0;
               s_next.tx_shift = {2'b11, s_reg.frame_mode_select ?
                  s_reg.ninth_tx_bit : 1'b1, s_reg.tx_hold};
               s_next.tx_cnt = 4'h1;
            end
         end
         TX_SEND: begin
            if (tx_bit) begin
               s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
               if (s_reg.tx_cnt == stop_idx + 4'h1) begin
                  s_next.tx_st = TX_IDLE;
                  s_next.txd = 1'b1;
               end else begin
                  s_next.txd = s_reg.tx_shift[0];
                  s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
                  ti_set = (s_reg.tx_cnt == stop_idx);
               end
            end
         end
         default: s_next.tx_st = TX_IDLE;
      endcase
      // Receiver, shift register apart from the held buffer
      case (s_reg.rx_st)
         RX_IDLE: begin
            if (start_det) begin
               s_next.rx_st = RX_START;
            end
         end
         RX_START: begin
            if (rx_smp) begin
               s_next.rx_st = rx_line ? RX_IDLE : RX_BITS;
               s_next.rx_cnt = 4'h0;
            end
         end
         RX_BITS: begin
            if (rx_smp) begin
               s_next.rx_shift = {rx_line, s_reg.rx_shift[8:1]};
               s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
               if (s_reg.rx_cnt == last_data) begin
                  s_next.rx_st = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (rx_smp) begin
               s_next.rx_st = RX_IDLE;
               chk = s_reg.frame_mode_select ? s_reg.rx_shift[8] : rx_line;
               ld = ~s_reg.rx_done_flag
                  & (~s_reg.multiproc_check_enable | chk);
               if (ld) begin
                  s_next.rx_buf = s_reg.frame_mode_select ?
                     s_reg.rx_shift[7:0] : s_reg.rx_shift[8:1];
                  s_next.ninth_rx_bit = chk;
               end
            end
         end
         default: s_next.rx_st = RX_IDLE;
      endcase
      if (~s_reg.receive_enable_bit) begin
         s_next.rx_st = RX_IDLE;
      end
      // Register writes take effect at the answering edge
      if (acc & avs_write & avs_byteenable[0]) begin
         case (avs_address)
            CTRL_OFS: begin
               s_next.frame_mode_select = avs_writedata[MODE_BIT];
               s_next.multiproc_check_enable = avs_writedata[MCE_BIT];
               s_next.receive_enable_bit = avs_writedata[REN_BIT];
               s_next.ninth_tx_bit = avs_writedata[TB8_BIT];
               if (!ld) begin
                  s_next.ninth_rx_bit = avs_writedata[RB8_BIT];
               end
            end
            DATA_OFS: begin
               s_next.tx_hold = avs_writedata[7:0];
               s_next.tx_pend = 1'b1;
            end
            TCFG_OFS: begin
               s_next.clk_src = avs_writedata[2:0];
               s_next.run = avs_writedata[RUN_BIT];
               s_next.ien = avs_writedata[IEN_BIT];
            end
            RELOAD_OFS: s_next.baud_timer_reload_byte = avs_writedata[7:0];
            TLOW_OFS: s_next.baud_timer_low_byte = avs_writedata[7:0];
            default: s_next.tx_pend = s_reg.tx_pend;
         endcase
      end
      // Flags: hardware set wins over software clear
      s_next.tx_done_flag = (wr_ctrl ? avs_writedata[TI_BIT]
         : s_reg.tx_done_flag) | ti_set;
      s_next.rx_done_flag = (wr_ctrl ? avs_writedata[RI_BIT]
         : s_reg.rx_done_flag) | ld;
      s_next.irq = s_next.ien
         & (s_next.tx_done_flag | s_next.rx_done_flag);
   end

   // State register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.waitr <= 1'b1;
         {s_reg.frame_mode_select, s_reg.multiproc_check_enable,
          s_reg.receive_enable_bit, s_reg.ninth_tx_bit, s_reg.ninth_rx_bit,
          s_reg.tx_done_flag, s_reg.rx_done_flag} <= 7'h00;
         s_reg.baud_timer_reload_byte <= BYTE_RST;
         s_reg.tx_st <= TX_IDLE;
         s_reg.rx_st <= RX_IDLE;
         s_reg.txd <= 1'b1;
         s_reg.rx_prev <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign avs_readdata = {24'h00_0000, s_reg.rdata};
   assign avs_waitrequest = s_reg.waitr;
   assign tx_line = s_reg.txd;
   assign irq = s_reg.irq;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   a_read_rx_buf: assert property (take && avs_read
      && avs_address == DATA_OFS |=> s_reg.rdata == $past(s_reg.rx_buf))
      else $error("data read did not return receive buffer");
   a_write_tx_hold: assert property (acc && avs_write
      && avs_byteenable[0] && avs_address == DATA_OFS
      |=> s_reg.tx_hold == $past(avs_writedata[7:0]) && s_reg.tx_pend)
      else $error("data write did not load transmit register");
   a_irq_follow: assert property (s_reg.ien
      && (s_reg.tx_done_flag || s_reg.rx_done_flag) |-> s_reg.irq)
      else $error("interrupt missing while flag set");
   a_flag_sticky: assert property (s_reg.rx_done_flag && !wr_ctrl
      |=> s_reg.rx_done_flag)
      else $error("receive flag cleared without software");
   a_rx_reload: assert property (start_det
      |=> s_reg.rx_timer == $past(s_reg.baud_timer_reload_byte)
      && s_reg.rx_st == RX_START)
      else $error("start did not reload receive counter");
   a_tx_reload: assert property (tx_ovf
      && !(acc && avs_write && avs_address == TLOW_OFS)
      |=> s_reg.baud_timer_low_byte == $past(s_reg.baud_timer_reload_byte))
      else $error("timer overflow did not reload");
   a_bit_halved: assert property (tx_bit |-> ##0 s_reg.tx_half
      ##1 !s_reg.tx_half)
      else $error("bit clock not half of overflow rate");
   a_rx_gate: assert property (s_reg.rx_done_flag
      |=> s_reg.rx_buf == $past(s_reg.rx_buf))
      else $error("receive buffer loaded while flag set");
   a_ti_at_stop: assert property ($rose(s_reg.tx_done_flag)
      && !$past(wr_ctrl) |-> s_reg.txd && s_reg.tx_st == TX_SEND)
      else $error("transmit flag not at stop bit start");
   a_rx_disabled: assert property (!s_reg.receive_enable_bit
      |=> s_reg.rx_st == RX_IDLE)
      else $error("receiver active while disabled");
   a_tx_sticky: assert property (s_reg.tx_done_flag && !wr_ctrl
      |=> s_reg.tx_done_flag)
      else $error("transmit flag cleared without software");
   // Hidden copy steps with the timer when neither reload applies
   a_rx_count: assert property (s_reg.run && tick && !rx_ovf
      && !start_det |=> s_reg.rx_timer == $past(s_reg.rx_timer) + 8'h01)
      else $error("receive counter did not count");

   c_tx_done: cover property ($rose(s_reg.tx_done_flag));
   c_rx_load: cover property (ld);
   c_false_start: cover property (s_reg.rx_st == RX_START && rx_smp
      && rx_line);
   c_rx_refused: cover property (s_reg.rx_st == RX_STOP && rx_smp && !ld);
   c_nine_load: cover property (ld && s_reg.frame_mode_select);
endmodule : uart_buffer_and_baud_generator

// file: verification/serial_peer.sv
// Remote serial peer: drives the receive line, captures transmit frames
`timescale 1ns/1ps
module serial_peer #(
   parameter int BIT = 8
) (
   input wire logic core_clk,
   input wire logic tx_line,
   output logic rx_line
);
   logic nine = 1'b0;
   logic [8:0] got = '0;
   logic [8:0] word;
   int frames = 0;
   int k;

   // Line idles high between frames
   initial rx_line = 1'b1;

   // One frame: start, data LSB first, optional ninth, stop, idle bit
   task automatic send(input logic [7:0] d, input logic b9,
      input logic use9, input logic stop);
      logic [11:0] f;
      f = use9 ? {1'b1, stop, b9, d, 1'b0} : {2'b11, stop, d, 1'b0};
      for (int i = 0; i < (use9 ? 12 : 11); i++) begin
         rx_line <= f[i];
         repeat (BIT) @(posedge core_clk);
      end
   endtask : send

   // Capture transmitted frames at mid-bit, LSB first
   always begin
      @(negedge tx_line);
      repeat (BIT / 2) @(posedge core_clk);
      word = '0;
      for (k = 0; k < (nine ? 9 : 8); k++) begin
         repeat (BIT) @(posedge core_clk);
         word[k] = tx_line;
      end
      repeat (BIT) @(posedge core_clk);
      got = word;
      frames++;
   end
endmodule : serial_peer

// file: verification/uart_buffer_and_baud_generator_test.sv
// Self-checking bench for the serial port and its baud timer
`timescale 1ns/1ps
module uart_buffer_and_baud_generator_test
   import uart_pkg::*;
;
   logic core_clk = 1'b0, rst = 1'b1;
   logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [4:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata;
   logic [3:0] avs_byteenable = 4'h1;
   logic ext_osc_clk = 1'b0, baud_timer_ext_input = 1'b1;
   logic rx_line, tx_line, irq;
   logic [7:0] q;
   logic hi = 1'b0;
   int fail_count = 0, tests_run = 0;

   uart_buffer_and_baud_generator uart_buffer_and_baud_generator_i (
      .core_clk, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .rx_line, .tx_line, .ext_osc_clk, .baud_timer_ext_input, .irq);

   serial_peer #(.BIT(8)) serial_peer_i (.core_clk, .tx_line, .rx_line);

   // 50 MHz core clock
   initial begin
      forever #10 core_clk = ~core_clk;
   end

   // External oscillator and timer pin toggle every core cycle
   always @(posedge core_clk) begin
      ext_osc_clk <= ~ext_osc_clk;
      baud_timer_ext_input <= ~baud_timer_ext_input;
   end

   // Counts and verdict, then stop
   task automatic summarize();
      $display("tests %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   // A wait ran out
   task automatic hang(input string nm);
      fail_count++;
      $display("FAIL %s expected answer seen timeout", nm);
      summarize();
   endtask : hang

   // Compare one value
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a,
      input logic [7:0] d);
      int n;
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h00_0000, d};
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (n == 20) hang("bus answer");
      q = avs_readdata[7:0];
      hi = hi | (|avs_readdata[31:8]);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   // Wait for the peer to finish capturing a frame
   task automatic wait_frame(input int want);
      int n;
      for (n = 0; n < 3000 && serial_peer_i.frames != want; n++)
         @(posedge core_clk);
      if (n == 3000) hang("tx frame");
   endtask : wait_frame

   // Reset values of every location, and an unmapped one
   task automatic t_reset();
      logic [4:0] ofs [6] = '{CTRL_OFS, DATA_OFS, TCFG_OFS, RELOAD_OFS,
         TLOW_OFS, 5'h14};
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, ofs[i], 8'h00);
         chk("reset read", i == 0 ? 16'h0040 : 16'h0000, 16'(q));
      end
      chk("irq idle", 16'h0000, 16'(irq));
      $display("reset test done");
   endtask : t_reset

   // 8-bit transmit, flag set and held, data read never shows tx byte
   task automatic t_tx8();
      bus(1'b1, RELOAD_OFS, 8'hFC);
      bus(1'b1, TCFG_OFS, 8'h08);
      bus(1'b1, CTRL_OFS, 8'h10);
      bus(1'b1, DATA_OFS, 8'hA5);
      wait_frame(1);
      chk("tx byte", 16'h00A5, 16'(serial_peer_i.got));
      bus(1'b0, CTRL_OFS, 8'h00);
      chk("tx done", 16'h0052, 16'(q));
      bus(1'b0, DATA_OFS, 8'h00);
      chk("data read", 16'h0000, 16'(q));
      bus(1'b0, CTRL_OFS, 8'h00);
      chk("flag held", 16'h0052, 16'(q));
      bus(1'b1, CTRL_OFS, 8'h10);
      $display("tx8 test done");
   endtask : t_tx8

   // 8-bit receive, second byte shifting while first unread, refusals
   task automatic t_rx8();
      serial_peer_i.send(8'h3C, 1'b0, 1'b0, 1'b1);
      bus(1'b0, CTRL_OFS, 8'h00);
      chk("rx flags", 16'h0055, 16'(q));
      fork
         serial_peer_i.send(8'hC3, 1'b0, 1'b0, 1'b1);
         begin
            bus(1'b0, DATA_OFS, 8'h00);
            chk("first byte", 16'h003C, 16'(q));
            bus(1'b1, CTRL_OFS, 8'h10);
         end
      join
      bus(1'b0, DATA_OFS, 8'h00);
      chk("second byte", 16'h00C3, 16'(q));
      serial_peer_i.send(8'h11, 1'b0, 1'b0, 1'b1);
      bus(1'b0, DATA_OFS, 8'h00);
      chk("overrun", 16'h00C3, 16'(q));
      bus(1'b1, CTRL_OFS, 8'h30);
      serial_peer_i.send(8'h22, 1'b0, 1'b0, 1'b0);
      bus(1'b0, CTRL_OFS, 8'h00);
      chk("bad stop", 16'h0000, 16'(q[RI_BIT]));
      $display("rx8 test done");
   endtask : t_rx8

   // 9-bit frames both ways with the address check on
   task automatic t_nine();
      serial_peer_i.nine = 1'b1;
      bus(1'b1, CTRL_OFS, 8'hB8);
      bus(1'b1, DATA_OFS, 8'h5A);
      wait_frame(2);
      chk("ninth tx", 16'h015A, 16'(serial_peer_i.got));
      serial_peer_i.send(8'h77, 1'b0, 1'b1, 1'b1);
      bus(1'b0, CTRL_OFS, 8'h00);
      chk("addr check", 16'h0000, 16'(q[RI_BIT]));
      serial_peer_i.send(8'h66, 1'b1, 1'b1, 1'b1);
      bus(1'b0, CTRL_OFS, 8'h00);
      chk("ninth rx", 16'h00FF, 16'(q));
      bus(1'b0, DATA_OFS, 8'h00);
      chk("ninth data", 16'h0066, 16'(q));
      $display("nine test done");
   endtask : t_nine

   // Interrupt from both flags, then from the transmit flag alone, cleared only by software
   task automatic t_irq();
      bus(1'b1, TCFG_OFS, 8'h18);
      repeat (2) @(posedge core_clk);
      chk("irq raised", 16'h0001, 16'(irq));
      bus(1'b1, CTRL_OFS, 8'h00);
      repeat (2) @(posedge core_clk);
      chk("irq cleared", 16'h0000, 16'(irq));
      serial_peer_i.nine = 1'b0;
      serial_peer_i.send(8'h99, 1'b0, 1'b0, 1'b1);
      bus(1'b0, CTRL_OFS, 8'h00);
      chk("rx disabled", 16'h0040, 16'(q));
      bus(1'b1, DATA_OFS, 8'h0F);
      wait_frame(3);
      chk("tx byte 3", 16'h000F, 16'(serial_peer_i.got));
      repeat (2) @(posedge core_clk);
      chk("irq on tx", 16'h0001, 16'(irq));
      bus(1'b1, CTRL_OFS, 8'h00);
      $display("irq test done");
   endtask : t_irq

   // Every clock source: nine low bits of a zero byte last 36 ticks
   task automatic t_src();
      int t [6] = '{1, 4, 12, 48, 16, 2};
      int c;
      int n;
      bus(1'b1, RELOAD_OFS, 8'hFE);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, TCFG_OFS, 8'h08 | 8'(i));
         bus(1'b1, DATA_OFS, 8'h00);
         for (n = 0; n < 500 && tx_line !== 1'b0; n++)
            @(posedge core_clk);
         if (n == 500) hang("tx start");
         for (c = 0; c < 4000 && tx_line === 1'b0; c++)
            @(posedge core_clk);
         chk("low run", 16'(36 * t[i]), 16'(c));
         repeat (8 * t[i]) @(posedge core_clk);
      end
      $display("source test done");
   endtask : t_src

   // Timer low byte access, stopped source, refused writes
   task automatic t_regs();
      bus(1'b1, TCFG_OFS, 8'h00);
      bus(1'b1, TLOW_OFS, 8'h12);
      bus(1'b1, TCFG_OFS, 8'h0E);
      repeat (50) @(posedge core_clk);
      bus(1'b0, TLOW_OFS, 8'h00);
      chk("stopped source", 16'h0012, 16'(q));
      bus(1'b0, TCFG_OFS, 8'h00);
      chk("timer cfg", 16'h000E, 16'(q));
      avs_byteenable <= 4'h0;
      bus(1'b1, RELOAD_OFS, 8'h33);
      avs_byteenable <= 4'h1;
      bus(1'b1, 5'h14, 8'h55);
      bus(1'b0, RELOAD_OFS, 8'h00);
      chk("lane off", 16'h00FE, 16'(q));
      bus(1'b0, 5'h14, 8'h00);
      chk("unmapped", 16'h0000, 16'(q));
      chk("upper bits", 16'h0000, 16'(hi));
      $display("regs test done");
   endtask : t_regs

   // Reset, then each scenario in turn
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      t_reset();
      t_tx8();
      t_rx8();
      t_nine();
      t_irq();
      t_src();
      t_regs();
      summarize();
   end
endmodule : uart_buffer_and_baud_generator_test
